/* File: design/lsje_pkg.sv */
/*
 * Package for the logic, select and jump execution block: opcodes, word
 * widths, branch codes, reset values and the request/answer structs.
 * Assumes a single 125 MHz clock and an outside sequencer that fetches
 * operands and performs storage writes.
 */
`default_nettype none
package lsje_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 30;    // Data word width
	localparam int unsigned OPC_W  = 6;     // Opcode width (two octal digits)
	localparam int unsigned ADDR_W = 15;    // Program address width
	localparam int unsigned CHAN_W = 8;     // Channel count for buffer jumps

	typedef logic [WORD_W-1:0] lsje_word_type;

	// ----------------------------------------------------------------
	// Opcodes (octal codes 26..63 written in hex)
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_ADD_Q   = 6'h16;
	localparam logic [5:0] OP_SUB_Q   = 6'h17;
	localparam logic [5:0] OP_ENT_YPQ = 6'h18;
	localparam logic [5:0] OP_ENT_YMQ = 6'h19;
	localparam logic [5:0] OP_STO_APQ = 6'h1A;
	localparam logic [5:0] OP_STO_AMQ = 6'h1B;
	localparam logic [5:0] OP_RPL_YPQ = 6'h1C;
	localparam logic [5:0] OP_RPL_YMQ = 6'h1D;
	localparam logic [5:0] OP_RPL_YP1 = 6'h1E;
	localparam logic [5:0] OP_RPL_YM1 = 6'h1F;
	localparam logic [5:0] OP_ENT_LP  = 6'h20;
	localparam logic [5:0] OP_ADD_LP  = 6'h21;
	localparam logic [5:0] OP_SUB_LP  = 6'h22;
	localparam logic [5:0] OP_CMP_MSK = 6'h23;
	localparam logic [5:0] OP_RPL_LP  = 6'h24;
	localparam logic [5:0] OP_RPL_ALP = 6'h25;
	localparam logic [5:0] OP_RPL_SLP = 6'h26;
	localparam logic [5:0] OP_STO_LP  = 6'h27;
	localparam logic [5:0] OP_SEL_SET = 6'h28;
	localparam logic [5:0] OP_SEL_CPL = 6'h29;
	localparam logic [5:0] OP_SEL_CLR = 6'h2A;
	localparam logic [5:0] OP_SEL_SUB = 6'h2B;
	localparam logic [5:0] OP_RSL_SET = 6'h2C;
	localparam logic [5:0] OP_RSL_CPL = 6'h2D;
	localparam logic [5:0] OP_RSL_CLR = 6'h2E;
	localparam logic [5:0] OP_RSL_SUB = 6'h2F;
	localparam logic [5:0] OP_JMP_AR  = 6'h30;
	localparam logic [5:0] OP_JMP_MAN = 6'h31;
	localparam logic [5:0] OP_JMP_IBF = 6'h32;
	localparam logic [5:0] OP_JMP_OBF = 6'h33;

	// ----------------------------------------------------------------
	// Constants and reset values
	// ----------------------------------------------------------------
	localparam lsje_word_type WORD_ONE  = 30'h00000001; // Seed for 36/37
	localparam lsje_word_type WORD_ZERO = 30'h00000000; // Reset value
	localparam logic [2:0]    BR_HALT   = 3'h4;         // Jump-and-halt code
	localparam int unsigned   EXEC_CYC  = 1;            // Cycles per operation

	// ----------------------------------------------------------------
	// Request and answer carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [OPC_W-1:0]  opcode;   // Function code
		logic [2:0]        branch;   // Branch condition field
		logic [2:0]        interp;   // Operand interpretation field
		lsje_word_type     operand;  // Operand value as fetched
		logic [ADDR_W-1:0] next_pc;  // Address of the next instruction
	} lsje_req_type;

	typedef struct packed {
		lsje_word_type     sum;      // Sum register after the operation
		lsje_word_type     aux;      // Auxiliary register after
		lsje_word_type     store;    // Word to write back
		logic              wr;       // Write-back request
		logic [2:0]        wr_interp;// Interpretation for the write
		logic              skip;     // Skip next instruction
		logic              jump;     // Jump taken
		logic [ADDR_W-1:0] pc;       // New program address
		logic              halt;     // Stop computation
		logic              int_en;   // Set interrupt enable
	} lsje_rsp_type;
endpackage : lsje_pkg
`default_nettype wire

/* File: design/lsje_exec.sv */
/*
 * Execution unit for opcodes 26 to 63: auxiliary add and subtract with skip,
 * enter/store/replace sums and differences, logical products, selective
 * operations and conditional jumps. One request per cycle, answer one cycle
 * later. Assumes the sequencer supplies the operand and performs storage
 * writes and instruction fetch; inputs are synchronous to i_clk.
 */
`default_nettype none
module lsje_exec #(
	parameter int unsigned CHANNELS = lsje_pkg::CHAN_W  // Buffer channels
) (
	input  wire logic                  i_clk,          // 125 MHz clock
	input  wire logic                  i_rst_n,        // Async reset, active low
	input  wire logic                  i_valid,        // Request strobe
	input  wire lsje_pkg::lsje_req_type i_req,         // Request fields
	input  wire lsje_pkg::lsje_word_type i_sum,        // Sum register in
	input  wire lsje_pkg::lsje_word_type i_aux,        // Auxiliary register in
	input  wire logic [2:0]            i_jump_keys,    // Manual jump keys 1..3
	input  wire logic [2:0]            i_stop_keys,    // Halt switches 5..7
	input  wire logic [CHANNELS-1:0]   i_ibuf_active,  // Input buffers active
	input  wire logic [CHANNELS-1:0]   i_obuf_active,  // Output buffers active
	output logic                       o_done,         // Answer strobe
	output lsje_pkg::lsje_rsp_type     o_rsp           // Answer fields
);
	// ----------------------------------------------------------------
	// Ones' complement helpers
	// ----------------------------------------------------------------
	// Sum with end-around carry; subtraction adds the complement
	// The fold-back add cannot carry again: a carry-out leaves
	// the low part at most all ones minus one
	function automatic lsje_pkg::lsje_word_type oc_add(input lsje_pkg::lsje_word_type a,
		input lsje_pkg::lsje_word_type b);
		logic [lsje_pkg::WORD_W:0] raw;
		raw = {1'b0, a} + {1'b0, b};
		oc_add = raw[lsje_pkg::WORD_W-1:0] + {{(lsje_pkg::WORD_W-1){1'b0}}, raw[lsje_pkg::WORD_W]};
	endfunction : oc_add

	// Zero test accepts both +0 and -0
	function automatic logic oc_zero(input lsje_pkg::lsje_word_type a);
		oc_zero = (a == '0) || (a == '1);
	endfunction : oc_zero

	// ----------------------------------------------------------------
	// Decoded request
	// ----------------------------------------------------------------
	lsje_pkg::lsje_word_type y;            // Operand value
	lsje_pkg::lsje_word_type a;            // Sum register
	lsje_pkg::lsje_word_type q;            // Auxiliary register
	lsje_pkg::lsje_word_type prod;         // Operand AND auxiliary
	lsje_pkg::lsje_word_type q_plus_y;     // Aux plus operand
	lsje_pkg::lsje_word_type q_minus_y;    // Aux minus operand
	lsje_pkg::lsje_word_type a_plus_q;     // Sum plus aux
	lsje_pkg::lsje_word_type a_minus_q;    // Sum minus aux
	lsje_pkg::lsje_word_type one_plus_y;   // One plus operand
	lsje_pkg::lsje_word_type one_minus_y;  // One minus operand
	lsje_pkg::lsje_word_type a_plus_p;     // Sum plus product
	lsje_pkg::lsje_word_type a_minus_p;    // Sum minus product
	logic [2:0]              br;           // Branch field
	logic [5:0]              op;           // Opcode

	assign y    = i_req.operand;
	assign a    = i_sum;
	assign q    = i_aux;
	assign br   = i_req.branch;
	assign op   = i_req.opcode;
	assign prod = y & q;
	assign q_plus_y    = oc_add(q, y);
	assign q_minus_y   = oc_add(q, ~y);
	assign a_plus_q    = oc_add(a, q);
	assign a_minus_q   = oc_add(a, ~q);
	assign one_plus_y  = oc_add(lsje_pkg::WORD_ONE, y);
	assign one_minus_y = oc_add(lsje_pkg::WORD_ONE, ~y);
	assign a_plus_p    = oc_add(a, prod);
	assign a_minus_p   = oc_add(a, ~prod);

	// ----------------------------------------------------------------
	// Selected channel buffer state
	// ----------------------------------------------------------------
	// Branch field names the channel; wider channel sets see only 0..7
	// Channel numbers above seven cannot be named by the field
	wire logic ibuf_sel = i_ibuf_active[br];
	wire logic obuf_sel = i_obuf_active[br];

	// ----------------------------------------------------------------
	// Result selection
	// ----------------------------------------------------------------
	lsje_pkg::lsje_word_type nxt_sum;   // Sum register result
	lsje_pkg::lsje_word_type nxt_aux;   // Aux register result
	lsje_pkg::lsje_word_type nxt_store; // Write-back word
	logic                    nxt_wr;    // Write-back request
	logic                    nxt_skip;  // Skip decision
	logic                    nxt_jump;  // Jump decision
	logic                    nxt_halt;  // Halt request
	logic                    nxt_ie;    // Interrupt enable request
	lsje_pkg::lsje_word_type cmp;       // Compare difference for 43
	logic                    par;       // Parity of result (odd = 1)

	// Standard skip on a word: positive, negative, zero, nonzero
	function automatic logic std_skip(input logic [2:0] j, input lsje_pkg::lsje_word_type w,
		input lsje_pkg::lsje_word_type other);
		case (j)
			3'h0: std_skip = 1'b0;
			3'h1: std_skip = 1'b1;
			3'h2: std_skip = ~other[lsje_pkg::WORD_W-1];
			3'h3: std_skip = other[lsje_pkg::WORD_W-1];
			3'h4: std_skip = oc_zero(w);
			3'h5: std_skip = ~oc_zero(w);
			3'h6: std_skip = ~w[lsje_pkg::WORD_W-1];
			default: std_skip = w[lsje_pkg::WORD_W-1];
		endcase
	endfunction : std_skip

	assign cmp = a_minus_p;

	// Combinational execution of one opcode
	// Defaults keep both registers, so unlisted codes change nothing
	always_comb begin
		nxt_sum   = a;
		nxt_aux   = q;
		nxt_store = lsje_pkg::WORD_ZERO;
		nxt_wr    = 1'b0;
		nxt_skip  = 1'b0;
		nxt_jump  = 1'b0;
		nxt_halt  = 1'b0;
		nxt_ie    = 1'b0;
		par       = 1'b0;
		case (op)
			// Aux arithmetic; sum register untouched by the double swap
			lsje_pkg::OP_ADD_Q, lsje_pkg::OP_SUB_Q: begin
				nxt_aux  = (op == lsje_pkg::OP_ADD_Q) ? q_plus_y : q_minus_y;
				nxt_skip = std_skip(br, nxt_aux, a);
			end

			// Enter aux plus operand into the sum register
			lsje_pkg::OP_ENT_YPQ: begin
				nxt_sum = q_plus_y;
			end

			// Enter complemented aux minus operand
			lsje_pkg::OP_ENT_YMQ: begin
				nxt_sum = ~q_minus_y;
			end

			// Sum plus or minus aux, then stored as the caller directs
			lsje_pkg::OP_STO_APQ, lsje_pkg::OP_STO_AMQ: begin
				nxt_sum   = (op == lsje_pkg::OP_STO_APQ) ? a_plus_q : a_minus_q;
				nxt_store = nxt_sum;
				nxt_wr    = 1'b1;
			end

			// Aux plus operand or complemented aux minus operand, result written back
			lsje_pkg::OP_RPL_YPQ, lsje_pkg::OP_RPL_YMQ: begin
				nxt_sum   = (op == lsje_pkg::OP_RPL_YPQ) ? q_plus_y : ~q_minus_y;
				nxt_store = nxt_sum;
				nxt_wr    = 1'b1;
			end

			// Seeded with one; the minus form is complemented
			lsje_pkg::OP_RPL_YP1, lsje_pkg::OP_RPL_YM1: begin
				nxt_sum   = (op == lsje_pkg::OP_RPL_YP1) ? one_plus_y : ~one_minus_y;
				nxt_store = nxt_sum;
				nxt_wr    = 1'b1;
			end

			// Logical product entered; write-back for the replace form
			lsje_pkg::OP_ENT_LP, lsje_pkg::OP_RPL_LP: begin
				nxt_sum = prod;
				par     = ^prod;
				// Parity replaces the sign tests on 2 and 3
				if (br == 3'h2) begin
					nxt_skip = ~par;
				end else if (br == 3'h3) begin
					nxt_skip = par;
				end else begin
					nxt_skip = std_skip(br, prod, q);
				end
				nxt_store = prod;
				nxt_wr    = (op == lsje_pkg::OP_RPL_LP);
			end

			// Masked product added to or taken from the sum
			lsje_pkg::OP_ADD_LP, lsje_pkg::OP_SUB_LP: begin
				nxt_sum = (op == lsje_pkg::OP_ADD_LP) ? a_plus_p : a_minus_p;
			end

			// Masked compare: skip decision only
			lsje_pkg::OP_CMP_MSK: begin
				// Difference judged only; no register changes
				nxt_skip = std_skip(br, cmp, q);
			end

			// Masked sum or difference, written back
			lsje_pkg::OP_RPL_ALP, lsje_pkg::OP_RPL_SLP: begin
				nxt_sum   = (op == lsje_pkg::OP_RPL_ALP) ? a_plus_p : a_minus_p;
				nxt_store = nxt_sum;
				nxt_wr    = 1'b1;
			end

			// Sum AND aux stored; sum register kept
			lsje_pkg::OP_STO_LP: begin
				nxt_store = a & q;
				nxt_wr    = 1'b1;
			end

			// Selective set, plain or written back
			lsje_pkg::OP_SEL_SET, lsje_pkg::OP_RSL_SET: begin
				nxt_sum   = a | y;
				nxt_store = nxt_sum;
				nxt_wr    = (op == lsje_pkg::OP_RSL_SET);
			end

			// Selective complement, plain or written back
			lsje_pkg::OP_SEL_CPL, lsje_pkg::OP_RSL_CPL: begin
				nxt_sum   = a ^ y;
				nxt_store = nxt_sum;
				nxt_wr    = (op == lsje_pkg::OP_RSL_CPL);
			end

			// Selective clear, plain or written back
			lsje_pkg::OP_SEL_CLR, lsje_pkg::OP_RSL_CLR: begin
				nxt_sum   = a & ~y;
				nxt_store = nxt_sum;
				nxt_wr    = (op == lsje_pkg::OP_RSL_CLR);
			end

			// Substitute under aux mask; clear-then-set gives the same word
			lsje_pkg::OP_SEL_SUB, lsje_pkg::OP_RSL_SUB: begin
				nxt_sum   = (a & ~q) | prod;
				nxt_store = nxt_sum;
				nxt_wr    = (op == lsje_pkg::OP_RSL_SUB);
			end

			// Arithmetic jump
			lsje_pkg::OP_JMP_AR: begin
				// Aux sign on 2/3, sum tests on 4..7
				nxt_jump = std_skip(br, a, q);
				nxt_ie   = (br == 3'h0) || (br == 3'h1);
			end

			// Manual keys; a halt always comes with a jump
			lsje_pkg::OP_JMP_MAN: begin
				if (br == 3'h0) begin
					nxt_jump = 1'b1;
				end else if (br < lsje_pkg::BR_HALT) begin
					nxt_jump = i_jump_keys[br[1:0] - 2'h1];
				end else if (br == lsje_pkg::BR_HALT) begin
					nxt_jump = 1'b1;
					nxt_halt = 1'b1;
				end else begin
					// Jump regardless; halt only if its switch is set
					nxt_jump = 1'b1;
					nxt_halt = i_stop_keys[br[1:0] - 2'h1];
				end
			end

			// Jump on an active input buffer
			lsje_pkg::OP_JMP_IBF: begin
				nxt_jump = ibuf_sel;
			end

			// Jump on an active output buffer
			lsje_pkg::OP_JMP_OBF: begin
				nxt_jump = obuf_sel;
			end

			// Codes outside this range leave the registers as they are
			default: begin
				nxt_sum = a;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Answer register
	// ----------------------------------------------------------------
	lsje_pkg::lsje_rsp_type rsp_ff;  // Registered answer
	logic                   done_ff; // Registered strobe
	lsje_pkg::lsje_rsp_type nxt_rsp; // Answer to be captured

	// Jump loads the operand's low bits, else the sequential address
	always_comb begin
		nxt_rsp           = rsp_ff;
		nxt_rsp.sum       = nxt_sum;
		nxt_rsp.aux       = nxt_aux;
		nxt_rsp.store     = nxt_store;
		nxt_rsp.wr        = nxt_wr;
		nxt_rsp.wr_interp = i_req.interp;
		nxt_rsp.skip      = nxt_skip;
		nxt_rsp.jump      = nxt_jump;
		nxt_rsp.pc        = nxt_jump ? y[lsje_pkg::ADDR_W-1:0] : i_req.next_pc;
		nxt_rsp.halt      = nxt_halt;
		nxt_rsp.int_en    = nxt_ie;
	end

	// Capture on a valid request; pulse fields return to zero otherwise
	// Data fields hold between requests so a slow caller can still read them
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsp_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= i_valid;
			if (i_valid) begin
				rsp_ff <= nxt_rsp;
			end else begin
				rsp_ff.wr     <= 1'b0;
				rsp_ff.skip   <= 1'b0;
				rsp_ff.jump   <= 1'b0;
				rsp_ff.halt   <= 1'b0;
				rsp_ff.int_en <= 1'b0;
			end
		end
	end

	assign o_done = done_ff;
	assign o_rsp  = rsp_ff;
endmodule : lsje_exec
`default_nettype wire

/* File: tb/lsje_exec_monitor.sv */
/*
 * Port checker for lsje_exec: answer timing, flag pulses and a set of
 * per-opcode results tied to the request of the cycle before.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`default_nettype none
module lsje_exec_monitor #(
	parameter int unsigned CHANNELS = 8         // Buffer channels
) (
	input wire logic                    i_clk,
	input wire logic                    i_rst_n,
	input wire logic                    i_valid,
	input wire lsje_pkg::lsje_req_type  i_req,
	input wire lsje_pkg::lsje_word_type i_sum,
	input wire lsje_pkg::lsje_word_type i_aux,
	input wire logic [2:0]              i_jump_keys,
	input wire logic [2:0]              i_stop_keys,
	input wire logic [CHANNELS-1:0]     i_ibuf_active,
	input wire logic [CHANNELS-1:0]     i_obuf_active,
	input wire logic                    o_done,
	input wire lsje_pkg::lsje_rsp_type  o_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic ibuf_sel;                             // Buffer bit named by branch
	assign ibuf_sel = i_ibuf_active[i_req.branch];
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Request of one opcode taken
	sequence s_op(logic [5:0] op);
		i_valid && i_req.opcode == op;
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_done; i_valid |=> o_done; endproperty
	a_done: assert property (p_done) else $error("answer strobe missing");
	property p_pulse; !o_done |-> !(o_rsp.wr || o_rsp.skip || o_rsp.jump || o_rsp.halt || o_rsp.int_en); endproperty
	a_pulse: assert property (p_pulse) else $error("flag outside answer");
	property p_aux_sum; s_op(lsje_pkg::OP_ADD_Q) or s_op(lsje_pkg::OP_SUB_Q) |=> o_rsp.sum == $past(i_sum); endproperty
	a_aux_sum: assert property (p_aux_sum) else $error("sum moved on aux op");
	property p_cmp; s_op(lsje_pkg::OP_CMP_MSK) |=> o_rsp.sum == $past(i_sum) && o_rsp.aux == $past(i_aux) && !o_rsp.wr;
	endproperty
	a_cmp: assert property (p_cmp) else $error("masked compare changed state");
	property p_ent_lp; s_op(lsje_pkg::OP_ENT_LP) |=> o_rsp.sum == ($past(i_req.operand) & $past(i_aux)); endproperty
	a_ent_lp: assert property (p_ent_lp) else $error("logical product wrong");
	property p_sto_lp; s_op(lsje_pkg::OP_STO_LP) |=> o_rsp.wr && o_rsp.store == ($past(i_sum) & $past(i_aux)); endproperty
	a_sto_lp: assert property (p_sto_lp) else $error("stored product wrong");
	property p_sel_set; s_op(lsje_pkg::OP_SEL_SET) |=> o_rsp.sum == ($past(i_sum) | $past(i_req.operand)); endproperty
	a_sel_set: assert property (p_sel_set) else $error("selective set wrong");
	property p_sel_sub; s_op(lsje_pkg::OP_SEL_SUB) |=>
		o_rsp.sum == (($past(i_sum) & ~$past(i_aux)) | ($past(i_req.operand) & $past(i_aux))); endproperty
	a_sel_sub: assert property (p_sel_sub) else $error("selective substitute wrong");
	property p_halt; s_op(lsje_pkg::OP_JMP_MAN) ##0 i_req.branch == 3'h4 |=> o_rsp.jump && o_rsp.halt &&
		{15'h0000, o_rsp.pc} == ($past(i_req.operand) & 30'h00007FFF); endproperty
	a_halt: assert property (p_halt) else $error("jump and halt wrong");
	property p_stop_jmp; s_op(lsje_pkg::OP_JMP_MAN) ##0 i_req.branch > 3'h4 |=> o_rsp.jump; endproperty
	a_stop_jmp: assert property (p_stop_jmp) else $error("stop switch jump missing");
	property p_ibuf; s_op(lsje_pkg::OP_JMP_IBF) |=> o_rsp.jump == $past(ibuf_sel); endproperty
	a_ibuf: assert property (p_ibuf) else $error("input buffer jump wrong");
	property p_int_en; s_op(lsje_pkg::OP_JMP_AR) ##0 i_req.branch < 3'h2 |=> o_rsp.int_en &&
		o_rsp.jump == $past(i_req.branch[0]); endproperty
	a_int_en: assert property (p_int_en) else $error("interrupt enable wrong");
	property p_seq_pc; o_done && !o_rsp.jump |-> o_rsp.pc == $past(i_req.next_pc); endproperty
	a_seq_pc: assert property (p_seq_pc) else $error("sequential address wrong");
endmodule : lsje_exec_monitor
bind lsje_exec lsje_exec_monitor #(.CHANNELS(CHANNELS)) lsje_exec_monitor_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_valid(i_valid), .i_req(i_req), .i_sum(i_sum), .i_aux(i_aux), .i_jump_keys(i_jump_keys),
	.i_stop_keys(i_stop_keys), .i_ibuf_active(i_ibuf_active), .i_obuf_active(i_obuf_active),
	.o_done(o_done), .o_rsp(o_rsp));
`default_nettype wire

/* File: tb/lsje_exec_test.sv */
/*
 * Self-checking bench for lsje_exec: one request per call, answer checked
 * in the cycle after. Assumes the bound port checker is compiled first.
 */
`default_nettype none
module lsje_exec_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Stimulus values and expected masks (bit j per branch code)
	// ----------------------------------------------------------------
	localparam lsje_pkg::lsje_word_type S = 30'h0F0F1234;
	localparam lsje_pkg::lsje_word_type Q = 30'h00FF00F5;
	localparam lsje_pkg::lsje_word_type Y = 30'h0A0B0C0D;
	localparam logic [7:0] M_SKN = 8'hAA;      // Sub-aux skips, sum negative
	localparam logic [7:0] M_SKP = 8'h66;      // Add-aux skips, sum positive
	localparam logic [7:0] M_J60 = 8'h5A;      // Sum +0, aux negative
	localparam logic [7:0] M_J61 = 8'hF5;      // Key 2, codes 4..7 always jump
	localparam logic [7:0] M_H61 = 8'hB0;
	logic                    i_clk;
	logic                    i_rst_n;
	logic                    i_valid;
	lsje_pkg::lsje_req_type  i_req;
	lsje_pkg::lsje_word_type i_sum;
	lsje_pkg::lsje_word_type i_aux;
	logic [2:0]              i_jump_keys;
	logic [2:0]              i_stop_keys;
	logic [7:0]              i_ibuf_active;
	logic [7:0]              i_obuf_active;
	logic                    o_done;
	lsje_pkg::lsje_rsp_type  o_rsp;
	int                      n_fail;
	int                      tests_run;
	lsje_exec lsje_exec_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_req(i_req), .i_sum(i_sum),
		.i_aux(i_aux), .i_jump_keys(i_jump_keys), .i_stop_keys(i_stop_keys), .i_ibuf_active(i_ibuf_active),
		.i_obuf_active(i_obuf_active), .o_done(o_done), .o_rsp(o_rsp));
	// Free-running 8 ns clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// ----------------------------------------------------------------
	// Reference arithmetic: ones' complement, end-around carry
	// ----------------------------------------------------------------
	function automatic lsje_pkg::lsje_word_type oc_add(input lsje_pkg::lsje_word_type a, b);
		logic [30:0] t;
		t = {1'b0, a} + {1'b0, b};
		return t[29:0] + {29'h0, t[30]};
	endfunction : oc_add
	function automatic lsje_pkg::lsje_word_type model(input logic [5:0] op, input lsje_pkg::lsje_word_type s, q, y);
		case (op)
			lsje_pkg::OP_ENT_YPQ, lsje_pkg::OP_RPL_YPQ: return oc_add(q, y);
			lsje_pkg::OP_ENT_YMQ, lsje_pkg::OP_RPL_YMQ: return ~oc_add(q, ~y);
			lsje_pkg::OP_STO_APQ: return oc_add(s, q);
			lsje_pkg::OP_STO_AMQ: return oc_add(s, ~q);
			lsje_pkg::OP_RPL_YP1: return oc_add(30'h00000001, y);
			lsje_pkg::OP_RPL_YM1: return ~oc_add(30'h00000001, ~y);
			lsje_pkg::OP_ENT_LP, lsje_pkg::OP_RPL_LP: return y & q;
			lsje_pkg::OP_ADD_LP, lsje_pkg::OP_RPL_ALP: return oc_add(s, y & q);
			lsje_pkg::OP_SUB_LP, lsje_pkg::OP_RPL_SLP: return oc_add(s, ~(y & q));
			lsje_pkg::OP_STO_LP: return s & q;
			lsje_pkg::OP_SEL_SET, lsje_pkg::OP_RSL_SET: return s | y;
			lsje_pkg::OP_SEL_CPL, lsje_pkg::OP_RSL_CPL: return s ^ y;
			lsje_pkg::OP_SEL_CLR, lsje_pkg::OP_RSL_CLR: return s & ~y;
			lsje_pkg::OP_SEL_SUB, lsje_pkg::OP_RSL_SUB: return (s & ~q) | (y & q);
			default: return s;                  // Masked compare keeps the sum
		endcase
	endfunction : model
	// Flag pulses in struct order
	function automatic logic [4:0] flags();
		return {o_rsp.wr, o_rsp.skip, o_rsp.jump, o_rsp.halt, o_rsp.int_en};
	endfunction : flags
	// ----------------------------------------------------------------
	// Compare, request and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input string n, input lsje_pkg::lsje_word_type e, g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word
	task automatic chk_flags(input string n, input logic [4:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : chk_flags
	// One request; the answer is looked at in its one-cycle window
	task automatic exec(input logic [5:0] op, input logic [2:0] j, input lsje_pkg::lsje_word_type y, s, q);
		@(posedge i_clk);
		i_valid <= 1'b1;
		i_req <= '{opcode: op, branch: j, interp: 3'h3, operand: y, next_pc: 15'h0101};
		i_sum <= s;
		i_aux <= q;
		@(posedge i_clk);
		i_valid <= 1'b0;
		#1;
		chk_word("done", 30'h00000001, {29'h0, o_done});
	endtask : exec
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	// Hang guard
	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [5:0] op;
		logic [2:0] j;
		logic       wr;
		lsje_pkg::lsje_word_type e;
		{i_rst_n, i_valid, i_req, i_sum, i_aux} = '0;
		{i_jump_keys, i_stop_keys, i_ibuf_active, i_obuf_active} = {3'h2, 3'h5, 8'hA5, 8'h3C};
		n_fail = 0;
		tests_run = 0;
		repeat (6) @(posedge i_clk);
		chk_flags("reset flags", 5'h00, flags());
		i_rst_n <= 1'b1;
		// Aux add and subtract with every skip code
		for (int i = 0; i < 8; i++) begin
			j = 3'(i);
			exec(lsje_pkg::OP_SUB_Q, j, 30'h0000000C, 30'h3FFFFFF0, 30'h0000000A);
			chk_word("aux27", 30'h3FFFFFFD, o_rsp.aux);
			chk_word("sum27", 30'h3FFFFFF0, o_rsp.sum);
			chk_flags("skip27", {1'b0, M_SKN[i], 3'h0}, flags());
			exec(lsje_pkg::OP_ADD_Q, j, 30'h00000005, S, 30'h0000000A);
			chk_word("aux26", 30'h0000000F, o_rsp.aux);
			chk_flags("skip26", {1'b0, M_SKP[i], 3'h0}, flags());
		end
		// Every data opcode from enter through replace substitute
		op = lsje_pkg::OP_ENT_YPQ;
		repeat (24) begin
			j = (op == lsje_pkg::OP_ENT_LP || op == lsje_pkg::OP_RPL_LP) ? 3'h3 : 3'h0;
			wr = op inside {[lsje_pkg::OP_STO_APQ:lsje_pkg::OP_RPL_YM1], [lsje_pkg::OP_RPL_LP:lsje_pkg::OP_STO_LP],
				[lsje_pkg::OP_RSL_SET:lsje_pkg::OP_RSL_SUB]};
			e = model(op, S, Q, Y);
			exec(op, j, Y, S, Q);
			if (op != lsje_pkg::OP_STO_LP) chk_word("sum", e, o_rsp.sum);
			chk_word("aux", Q, o_rsp.aux);
			if (wr) chk_word("store", e, o_rsp.store);
			chk_word("interp", 30'h00000003, {27'h0000000, o_rsp.wr_interp});
			chk_flags("flags", {wr, j[0] & ^(Y & Q), 3'h0}, flags());
			op++;
		end
		// Jumps on registers, keys and buffers
		for (int i = 0; i < 8; i++) begin
			j = 3'(i);
			exec(lsje_pkg::OP_JMP_AR, j, Y, 30'h00000000, 30'h20000000);
			chk_flags("jmp60", {2'h0, M_J60[i], 1'b0, i < 2}, flags());
			chk_word("pc60", M_J60[i] ? 30'h00000C0D : 30'h00000101, {15'h0000, o_rsp.pc});
			exec(lsje_pkg::OP_JMP_MAN, j, Y, S, Q);
			chk_flags("jmp61", {2'h0, M_J61[i], M_H61[i], 1'b0}, flags());
			exec(lsje_pkg::OP_JMP_IBF, j, Y, S, Q);
			chk_flags("jmp62", {2'h0, i_ibuf_active[i], 2'h0}, flags());
			exec(lsje_pkg::OP_JMP_OBF, j, Y, S, Q);
			chk_flags("jmp63", {2'h0, i_obuf_active[i], 2'h0}, flags());
		end
		complete_run();
	end
endmodule : lsje_exec_test
`default_nettype wire
